//--- hdl/mcuop_regs.sv
// operation register file of an 8-bit controller core behind an apb slave
// assumes synchronous active-low reset and single 250 MHz clock; pins sampled synchronously
//
// Functional notes
// RULE1: program store is six 1K-word pages; counter at word zero after reset.
// RULE2: reset starts at word 0; all interrupt sources vector to word 1.
// RULE3: indirect location has no storage; it accesses data at ram select address.
// RULE4: timer is 8-bit read/write register incrementing once per instruction cycle.
// RULE5: timer wrap from FFh to 00h sets interrupt status bit zero.
// RULE6: timer interrupt request is suppressed while mask bit zero is clear.
// RULE7: power-on or watchdog reset loads timer with zero.
// RULE8: program counter is 13 bits with an eight-level return stack.
// RULE9: low counter byte visible at its register; page bits supply upper bits.
// RULE10: power-on and watchdog reset clear the program counter.
// RULE11: carry is carry-out, inverted for borrow, rotated bit on rotates.
// RULE12: digit carry is carry out of bit three on add and subtract.
// RULE13: zero flag set when arithmetic or logic result is zero.
// RULE14: power-down flag set at power-on and watchdog clear, cleared entering sleep, kept on watchdog reset.
// RULE15: time-out flag set at power-on and watchdog clear, cleared on watchdog expiry.
// RULE16: port-change wake from sleep shows time-out one and power-down zero.
// RULE17: page bits 000 to 101 select pages 0 to 5 up to 17FF.
// RULE18: six low ram select bits address 00..3F; 00..1F common, above banked.
// RULE19: two bank bits choose bank 0..3 above common space, ignored within it.
// RULE20: control registers only reachable through control read and write accesses.
// RULE21: general data memory holds 144 bytes of sram.
// RULE22: port bits map to pins; reads return pin level, writes set output latch.
// RULE23: timer write replaces count at once; counting resumes from written value.
`timescale 1ns/1ps
`default_nettype none
module mcuop_regs
   import mcuop_pkg::*;
#(
   parameter int RAM_SIZE = RAM_BYTES
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [39:0] port_pins_i,
   output logic [39:0] port_latch_o,
   output logic [PC_W-1:0] fetch_addr_o,
   output logic irq_req_o
);
   logic [7:0] timer_ff, nxt_timer;
   logic [7:0] status_ff, nxt_status;
   logic [7:0] ram_sel_ff;
   logic [7:0] int_status_ff;
   logic [7:0] int_mask_ff;
   logic [PC_W-1:0] pc_ff, nxt_pc;
   logic [PC_W-1:0] stack_ff [STACK_DEPTH];
   logic [2:0] sp_ff;
   logic [39:0] latch_ff;
   logic [7:0] ram_ff [RAM_SIZE];
   logic [7:0] ctrl_space_ff;
   logic [7:0] alu_res_ff;
   logic ready_ff;
   logic [31:0] rdata_ff;
   logic err_ff;
   logic irq_ff;

   // an instruction cycle is a write of the cycle bit
   wire logic access = psel_i && penable_i && !ready_ff;
   wire logic wr = access && pwrite_i && pstrb_i[0];
   wire logic [7:0] ofs = paddr_i[7:0];
   wire logic hi_zero = (paddr_i[31:8] == 24'h000000);
   wire logic [7:0] wb = pwdata_i[7:0];
   wire logic [8:0] cc_bits = pwdata_i[8:0];
   wire logic cc_wr = wr && hi_zero && ofs == OFS_CORE_CTRL;
   wire logic instr_cycle = cc_wr && cc_bits[CC_CYCLE];
   wire logic wdt_reset = cc_wr && cc_bits[CC_WDT_RESET];

   // banked address map: common 32 bytes then four banks of 28
   function automatic logic [7:0] ram_index(input logic [7:0] sel);
      logic [7:0] loc;
      loc = {2'b00, sel[5:0]};
      if (sel[5:0] <= COMMON_TOP) begin // RULE18 RULE19
         ram_index = loc;
      end else begin
         ram_index = COMMON_ENTRIES + 8'(sel[7:6]) * BANK_ENTRIES + (loc - COMMON_ENTRIES); // RULE19
      end
   endfunction

   wire logic [7:0] ind_idx = ram_index(ram_sel_ff); // RULE3
   wire logic ind_ok = ram_sel_ff[5:0] < 6'(COMMON_ENTRIES + BANK_ENTRIES)
      || ram_sel_ff[5:0] <= COMMON_TOP;
   wire logic [7:0] dir_idx = ofs - OFS_RAM_BASE;
   wire logic dir_ok = ofs >= OFS_RAM_BASE && 32'(dir_idx) < RAM_SIZE; // RULE21

   // alu: operands a in bits 7:0, b in 15:8, op in 18:16
   wire logic [7:0] alu_a = pwdata_i[7:0];
   wire logic [7:0] alu_b = pwdata_i[15:8];
   wire mcuop_alu_op_t alu_op = mcuop_alu_op_t'(pwdata_i[18:16]);
   wire logic [8:0] sum = {1'b0, alu_a} + {1'b0, alu_b};
   wire logic [8:0] dif = {1'b0, alu_a} - {1'b0, alu_b};
   wire logic [4:0] nsum = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
   wire logic [4:0] ndif = {1'b0, alu_a[3:0]} - {1'b0, alu_b[3:0]};
   logic [7:0] alu_y;
   logic alu_c, alu_dc, alu_uc, alu_udc;
   always_comb begin
      alu_y = 8'h00;
      alu_c = status_ff[ST_C];
      alu_dc = status_ff[ST_DC];
      alu_uc = 1'b0;
      alu_udc = 1'b0;
      case (alu_op)
         ALU_ADD: begin
            alu_y = sum[7:0];
            alu_c = sum[8]; // RULE11
            alu_dc = nsum[4]; // RULE12
            alu_uc = 1'b1;
            alu_udc = 1'b1;
         end
         ALU_SUB: begin
            alu_y = dif[7:0];
            alu_c = !dif[8]; // RULE11
            alu_dc = !ndif[4]; // RULE12
            alu_uc = 1'b1;
            alu_udc = 1'b1;
         end
         ALU_AND: alu_y = alu_a & alu_b;
         ALU_OR: alu_y = alu_a | alu_b;
         ALU_XOR: alu_y = alu_a ^ alu_b;
         ALU_RRC: begin
            alu_y = {status_ff[ST_C], alu_a[7:1]};
            alu_c = alu_a[0]; // RULE11
            alu_uc = 1'b1;
         end
         ALU_RLC: begin
            alu_y = {alu_a[6:0], status_ff[ST_C]};
            alu_c = alu_a[7]; // RULE11
            alu_uc = 1'b1;
         end
         default: alu_y = 8'h00;
      endcase
   end
   wire logic alu_wr = wr && hi_zero && ofs == OFS_ALU;

   // read mux; the control space answers only through its own window
   logic [7:0] rd_byte;
   logic rd_hit;
   always_comb begin
      rd_byte = 8'h00;
      rd_hit = hi_zero;
      case (ofs)
         OFS_INDIRECT: rd_byte = ind_ok ? ram_ff[ind_idx] : 8'h00; // RULE3
         OFS_TIMER: rd_byte = timer_ff;
         OFS_PC_LOW: rd_byte = pc_ff[7:0]; // RULE9
         OFS_STATUS: rd_byte = status_ff;
         OFS_RAM_SEL: rd_byte = ram_sel_ff;
         OFS_PORT5: rd_byte = port_pins_i[7:0]; // RULE22
         OFS_PORT6: rd_byte = port_pins_i[15:8];
         OFS_PORT7: rd_byte = port_pins_i[23:16];
         OFS_PORT8: rd_byte = port_pins_i[31:24];
         OFS_PORT9: rd_byte = port_pins_i[39:32];
         OFS_INT_STATUS: rd_byte = int_status_ff;
         OFS_INT_MASK: rd_byte = int_mask_ff; // RULE20
         OFS_CORE_CTRL: rd_byte = {5'b00000, sp_ff};
         OFS_PC_FULL: rd_byte = {3'b000, pc_ff[PC_W-1:PAGE_LSB+0], 2'b00};
         OFS_ALU: rd_byte = alu_res_ff;
         OFS_CTRL_SPACE: rd_byte = ctrl_space_ff;
         default: begin
            rd_byte = dir_ok ? ram_ff[dir_idx] : 8'h00;
            rd_hit = hi_zero && dir_ok;
         end
      endcase
   end

   // timer: write wins over increment, overflow only on wrap
   wire logic tmr_wr = wr && hi_zero && ofs == OFS_TIMER;
   wire logic tmr_wrap = instr_cycle && !tmr_wr && timer_ff == TIMER_MAX; // RULE5
   always_comb begin
      nxt_timer = timer_ff;
      if (tmr_wr) begin
         nxt_timer = wb; // RULE23
      end else if (instr_cycle) begin
         nxt_timer = timer_ff + 8'h01; // RULE4
      end
   end

   // program counter: call/return via stack, interrupt to shared vector
   wire logic pc_wr = wr && hi_zero && ofs == OFS_PC_LOW;
   wire logic [2:0] page = status_ff[7:ST_PS_LSB];
   wire logic [PC_W-1:0] pc_inc = pc_ff + 13'h0001;
   always_comb begin
      nxt_pc = pc_ff;
      if (cc_wr && cc_bits[CC_IRQ_TAKE]) begin
         nxt_pc = INT_VECTOR; // RULE2
      end else if (cc_wr && cc_bits[CC_RET]) begin
         nxt_pc = stack_ff[sp_ff - 3'h1]; // RULE8
      end else if (cc_wr && cc_bits[CC_CALL]) begin
         nxt_pc = {page, 2'b00, wb}; // RULE9 RULE17
      end else if (pc_wr) begin
         nxt_pc = {page, pc_ff[PAGE_LSB-1:8], wb}; // RULE9
      end else if (instr_cycle) begin
         nxt_pc = (pc_ff == PC_LIMIT) ? RESET_VECTOR : pc_inc; // RULE1
      end
   end

   // status: flags from alu, power-down and time-out from core events
   wire logic st_wr = wr && hi_zero && ofs == OFS_STATUS;
   wire logic ps_ok = wb[7:ST_PS_LSB] <= PAGE_MAX; // RULE17
   always_comb begin
      nxt_status = status_ff;
      if (st_wr) begin
         nxt_status[ST_DC:ST_C] = wb[ST_DC:ST_C];
         nxt_status[ST_Z] = wb[ST_Z];
         if (ps_ok) begin
            nxt_status[7:ST_PS_LSB] = wb[7:ST_PS_LSB];
         end
      end
      if (alu_wr) begin
         if (alu_uc) nxt_status[ST_C] = alu_c; // RULE11
         if (alu_udc) nxt_status[ST_DC] = alu_dc; // RULE12
         nxt_status[ST_Z] = (alu_y == 8'h00); // RULE13
      end
      if (cc_wr) begin
         if (cc_bits[CC_WDT_CLEAR]) begin
            nxt_status[ST_PD] = 1'b1; // RULE14
            nxt_status[ST_TO] = 1'b1; // RULE15
         end else if (cc_bits[CC_WDT_EXPIRE]) begin
            nxt_status[ST_TO] = 1'b0; // RULE15
         end else if (cc_bits[CC_POWER_DOWN]) begin
            nxt_status[ST_PD] = 1'b0; // RULE14
            nxt_status[ST_TO] = 1'b1;
         end else if (cc_bits[CC_PORT_WAKE]) begin
            nxt_status[ST_PD] = 1'b0; // RULE16
            nxt_status[ST_TO] = 1'b1; // RULE16
         end
      end
   end

   wire logic ram_sel_wr = wr && hi_zero && ofs == OFS_RAM_SEL;
   wire logic ind_wr = wr && hi_zero && ofs == OFS_INDIRECT && ind_ok;
   wire logic dir_wr = wr && hi_zero && dir_ok;
   wire logic ist_wr = wr && hi_zero && ofs == OFS_INT_STATUS;
   wire logic imk_wr = wr && hi_zero && ofs == OFS_INT_MASK;
   wire logic csp_wr = wr && hi_zero && ofs == OFS_CTRL_SPACE;
   // write-one-to-clear; a wrap in the same cycle wins
   wire logic [7:0] nxt_int_status = (ist_wr ? (int_status_ff & ~wb) : int_status_ff)
      | {7'h00, tmr_wrap}; // RULE5

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         timer_ff <= TIMER_RST; // RULE7
         pc_ff <= RESET_VECTOR; // RULE10
         sp_ff <= 3'h0;
         status_ff <= 8'((1 << ST_PD) | (1 << ST_TO)); // RULE14 RULE15
         ram_sel_ff <= 8'h00;
         int_status_ff <= 8'h00;
         int_mask_ff <= 8'h00;
         latch_ff <= 40'h00_0000_0000;
         ctrl_space_ff <= 8'h00;
         alu_res_ff <= 8'h00;
      end else begin
         if (wdt_reset) begin
            timer_ff <= TIMER_RST; // RULE7
            pc_ff <= RESET_VECTOR; // RULE10
            sp_ff <= 3'h0;
            status_ff[ST_TO] <= 1'b0; // RULE14
         end else begin
            timer_ff <= nxt_timer;
            pc_ff <= nxt_pc;
            status_ff <= nxt_status;
            if (cc_wr && (cc_bits[CC_CALL] || cc_bits[CC_IRQ_TAKE])) begin
               stack_ff[sp_ff] <= pc_inc; // RULE8
               sp_ff <= sp_ff + 3'h1;
            end else if (cc_wr && cc_bits[CC_RET]) begin
               sp_ff <= sp_ff - 3'h1;
            end
         end
         int_status_ff <= nxt_int_status;
         if (ram_sel_wr) ram_sel_ff <= wb;
         if (imk_wr) int_mask_ff <= wb;
         if (csp_wr) ctrl_space_ff <= wb; // RULE20
         if (alu_wr) alu_res_ff <= alu_y;
         if (ind_wr) ram_ff[ind_idx] <= wb; // RULE3
         else if (dir_wr) ram_ff[dir_idx] <= wb; // RULE21
         if (wr && hi_zero && ofs == OFS_PORT5) latch_ff[7:0] <= wb; // RULE22
         if (wr && hi_zero && ofs == OFS_PORT6) latch_ff[15:8] <= wb;
         if (wr && hi_zero && ofs == OFS_PORT7) latch_ff[23:16] <= wb;
         if (wr && hi_zero && ofs == OFS_PORT8) latch_ff[31:24] <= wb;
         if (wr && hi_zero && ofs == OFS_PORT9) latch_ff[39:32] <= wb;
      end
   end

   // irq: status bit gated by mask
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= int_status_ff[IRQ_TIMER] && int_mask_ff[IRQ_TIMER]; // RULE6
      end
   end

   // apb: one wait state, ready pulses in the second access cycle
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         ready_ff <= 1'b0;
         rdata_ff <= RDATA_ZERO;
         err_ff <= 1'b0;
      end else begin
         ready_ff <= access;
         err_ff <= access && !rd_hit;
         if (access && !pwrite_i) rdata_ff <= {24'h000000, rd_byte};
         else if (access) rdata_ff <= RDATA_ZERO;
      end
   end

   assign prdata_o = rdata_ff;
   assign pready_o = ready_ff;
   assign pslverr_o = err_ff;
   assign port_latch_o = latch_ff;
   assign fetch_addr_o = pc_ff;
   assign irq_req_o = irq_ff;

   timer_wrap_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE5
      (instr_cycle && !tmr_wr && timer_ff == TIMER_MAX) |=> int_status_ff[IRQ_TIMER]
      && timer_ff == 8'h00) else $error("timer wrap did not set flag");
   timer_count_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE4
      (instr_cycle && !tmr_wr && !wdt_reset) |=> timer_ff == $past(timer_ff) + 8'h01)
      else $error("timer did not increment");
   timer_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE23
      (tmr_wr && !wdt_reset) |=> timer_ff == $past(wb)) else $error("timer write lost");
   irq_mask_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE6
      !int_mask_ff[IRQ_TIMER] |=> !irq_req_o) else $error("masked timer irq raised");
   wdt_reset_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE10
      wdt_reset |=> pc_ff == RESET_VECTOR && timer_ff == TIMER_RST
      && status_ff[ST_PD] == $past(status_ff[ST_PD])) else $error("watchdog reset wrong");
   irq_vector_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE2
      (cc_wr && cc_bits[CC_IRQ_TAKE] && !wdt_reset) |=> pc_ff == INT_VECTOR)
      else $error("interrupt not at vector");
   zero_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE13
      (alu_wr && !wdt_reset && !cc_wr) |=> status_ff[ST_Z] == (alu_res_ff == 8'h00))
      else $error("zero flag mismatch");
   page_range_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE17
      status_ff[7:ST_PS_LSB] <= PAGE_MAX) else $error("page select out of range");
   wake_flags_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE16
      (cc_wr && cc_bits[3:0] == 4'h8 && !wdt_reset) |=> status_ff[ST_TO] && !status_ff[ST_PD])
      else $error("wake flags wrong");
   // side effects of stack, counter, flag, port and indirect writes; irq follows enabled status
   stack_push_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE8
      (cc_wr && (cc_bits[CC_CALL] || cc_bits[CC_IRQ_TAKE]) && !wdt_reset)
      |=> sp_ff == $past(sp_ff) + 3'h1) else $error("stack push lost");
   stack_pop_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE8
      (cc_wr && cc_bits[CC_RET] && !cc_bits[CC_CALL] && !cc_bits[CC_IRQ_TAKE] && !wdt_reset)
      |=> sp_ff == $past(sp_ff) - 3'h1) else $error("stack pop lost");
   irq_follow_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE6
      (int_status_ff[IRQ_TIMER] && int_mask_ff[IRQ_TIMER]) |=> irq_req_o)
      else $error("enabled timer irq not raised");
   ind_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE3
      ind_wr |=> ram_ff[$past(ind_idx)] == $past(wb))
      else $error("indirect write missed ram");
   pc_low_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE9
      pc_wr |=> pc_ff[7:0] == $past(wb) && pc_ff[PC_W-1:PAGE_LSB] == $past(page))
      else $error("counter low write wrong");
   wdt_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE14
      (cc_wr && cc_bits[CC_WDT_CLEAR] && !wdt_reset) |=> status_ff[ST_PD] && status_ff[ST_TO])
      else $error("watchdog clear flags wrong");
   expire_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE15
      (cc_wr && cc_bits[CC_WDT_EXPIRE] && !cc_bits[CC_WDT_CLEAR]) |=> !status_ff[ST_TO])
      else $error("time-out flag not cleared");
   port_latch_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE22
      (wr && hi_zero && ofs == OFS_PORT5) |=> port_latch_o[7:0] == $past(wb))
      else $error("port latch not written");
   carry_add_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE11
      (alu_wr && alu_op == ALU_ADD) |=> status_ff[ST_C] == $past(sum[8]))
      else $error("add carry wrong");
endmodule
`default_nettype wire

//--- inc/mcuop_pkg.sv
// package for the operation register block: offsets, field positions, resets, types
// assumes a 32-bit apb slave in front of the register file
package mcuop_pkg;
   localparam logic [7:0] OFS_INDIRECT = 8'h00;
   localparam logic [7:0] OFS_TIMER = 8'h04;
   localparam logic [7:0] OFS_PC_LOW = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_RAM_SEL = 8'h10;
   localparam logic [7:0] OFS_PORT5 = 8'h14;
   localparam logic [7:0] OFS_PORT6 = 8'h18;
   localparam logic [7:0] OFS_PORT7 = 8'h1C;
   localparam logic [7:0] OFS_PORT8 = 8'h20;
   localparam logic [7:0] OFS_PORT9 = 8'h24;
   localparam logic [7:0] OFS_INT_STATUS = 8'h28;
   localparam logic [7:0] OFS_INT_MASK = 8'h2C;
   localparam logic [7:0] OFS_CORE_CTRL = 8'h30;
   localparam logic [7:0] OFS_PC_FULL = 8'h34;
   localparam logic [7:0] OFS_ALU = 8'h38;
   localparam logic [7:0] OFS_CTRL_SPACE = 8'h3C;
   localparam logic [7:0] OFS_RAM_BASE = 8'h80;
   localparam int PC_W = 13;
   localparam int STACK_DEPTH = 8;
   localparam int RAM_BYTES = 144;
   localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
   localparam logic [PC_W-1:0] INT_VECTOR = 13'h0001;
   localparam logic [PC_W-1:0] PC_LIMIT = 13'h17FF;
   localparam logic [2:0] PAGE_MAX = 3'h5;
   localparam int PAGE_LSB = 10;
   localparam logic [7:0] TIMER_RST = 8'h00;
   localparam logic [7:0] TIMER_MAX = 8'hFF;
   localparam logic [5:0] COMMON_TOP = 6'h1F;
   localparam logic [7:0] COMMON_ENTRIES = 8'h20;
   localparam logic [7:0] BANK_ENTRIES = 8'h1C;
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   localparam int ST_PD = 3;
   localparam int ST_TO = 4;
   localparam int ST_PS_LSB = 5;
   localparam int IRQ_TIMER = 0;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
   // core control register bit positions
   localparam int CC_WDT_CLEAR = 0;
   localparam int CC_POWER_DOWN = 1;
   localparam int CC_WDT_EXPIRE = 2;
   localparam int CC_PORT_WAKE = 3;
   localparam int CC_CALL = 4;
   localparam int CC_RET = 5;
   localparam int CC_IRQ_TAKE = 6;
   localparam int CC_CYCLE = 7;
   localparam int CC_WDT_RESET = 8;
   // alu operation codes
   typedef enum logic [2:0] {
      ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_RRC, ALU_RLC
   } mcuop_alu_op_t;
   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic [7:0] wdata;
      logic access;
   } mcuop_req_t;
endpackage

//--- testbench/mcu_operation_registers_bench.sv
// self-checking bench for the operation register block, driven over apb
// assumes the design package is compiled first; one 250 MHz clock, no partner model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, (a), (e)); end end
module mcu_operation_registers_bench;
   import mcuop_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0000_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [39:0] pins = 40'h99_88_77_66_55;
   logic [39:0] latch;
   logic [PC_W-1:0] fetch;
   logic irq;
   logic [31:0] rdata;
   logic serr;
   int err_count = 0;
   int checked = 0;

   mcuop_regs u_mcuop_regs (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .psel_i(psel),
      .penable_i(penable),
      .pwrite_i(pwrite),
      .paddr_i(paddr),
      .pwdata_i(pwdata),
      .pstrb_i(4'hF),
      .prdata_o(prdata),
      .pready_o(pready),
      .pslverr_o(pslverr),
      .port_pins_i(pins),
      .port_latch_o(latch),
      .fetch_addr_o(fetch),
      .irq_req_o(irq)
   );

   initial begin
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // request held until pready is sampled high; read data taken at that edge
   task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge sys_clk_i);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rdata = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         err_count++;
         $display("unexpected at %0t: no ready", $time);
         close_out();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb({24'h0, a}, 1'b1, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb({24'h0, a}, 1'b0, 32'h0000_0000);
   endtask

   // registered outputs land one edge after the write
   task automatic settle();
      @(posedge sys_clk_i);
      #1;
   endtask

   task automatic t_reset();
      `CHK(fetch, RESET_VECTOR)
      `CHK(latch, 40'h00_0000_0000)
      rd(OFS_TIMER);
      `CHK(rdata, 32'h0000_0000)
      rd(OFS_PC_LOW);
      `CHK(rdata, 32'h0000_0000)
      rd(OFS_STATUS);
      `CHK(rdata, 32'h0000_0018)
      $display("reset values done");
   endtask

   task automatic t_timer();
      wr(OFS_TIMER, 32'h0000_00FD);
      rd(OFS_TIMER);
      `CHK(rdata, 32'h0000_00FD)
      repeat (3) wr(OFS_CORE_CTRL, 32'h0000_0080);
      rd(OFS_TIMER);
      `CHK(rdata, 32'h0000_0000)
      rd(OFS_INT_STATUS);
      `CHK(rdata[0], 1'b1)
      settle();
      `CHK(irq, 1'b0)
      wr(OFS_INT_MASK, 32'h0000_0001);
      settle();
      `CHK(irq, 1'b1)
      wr(OFS_INT_STATUS, 32'h0000_0001);
      settle();
      `CHK(irq, 1'b0)
      $display("timer done");
   endtask

   task automatic t_page();
      wr(OFS_STATUS, 32'h0000_00A0);
      wr(OFS_STATUS, 32'h0000_00C0);
      rd(OFS_STATUS);
      `CHK(rdata[7:5], 3'h5)
      wr(OFS_PC_FULL, 32'h0000_0014);
      wr(OFS_PC_LOW, 32'h0000_0055);
      settle();
      `CHK(fetch, 13'h1455)
      rd(OFS_PC_LOW);
      `CHK(rdata, 32'h0000_0055)
      wr(OFS_CORE_CTRL, 32'h0000_0040);
      settle();
      `CHK(fetch, INT_VECTOR)
      rd(OFS_CORE_CTRL);
      `CHK(rdata, 32'h0000_0001)
      wr(OFS_CORE_CTRL, 32'h0000_0020);
      rd(OFS_CORE_CTRL);
      `CHK(rdata, 32'h0000_0000)
      `CHK(fetch, 13'h1456)
      // call target low byte shares the word with the command bits
      wr(OFS_CORE_CTRL, 32'h0000_0010);
      settle();
      `CHK(fetch, 13'h1410)
      rd(OFS_PC_FULL);
      `CHK(rdata, 32'h0000_0014)
      wr(OFS_CORE_CTRL, 32'h0000_0020);
      settle();
      `CHK(fetch, 13'h1457)
      $display("page and stack done");
   endtask

   task automatic alu(input mcuop_alu_op_t op, input logic [7:0] a, b, res, rm,
                      input logic [2:0] fl, fm);
      wr(OFS_ALU, {13'h0, op, b, a});
      rd(OFS_ALU);
      `CHK(rdata[7:0] & rm, res & rm)
      rd(OFS_STATUS);
      `CHK(rdata[2:0] & fm, fl & fm)
   endtask

   task automatic t_alu();
      alu(ALU_ADD, 8'h0F, 8'h01, 8'h10, 8'hFF, 3'b010, 3'b111);
      alu(ALU_ADD, 8'hFF, 8'h01, 8'h00, 8'hFF, 3'b111, 3'b111);
      alu(ALU_SUB, 8'h05, 8'h03, 8'h02, 8'hFF, 3'b011, 3'b111);
      alu(ALU_SUB, 8'h03, 8'h05, 8'hFE, 8'hFF, 3'b000, 3'b111);
      alu(ALU_AND, 8'hF0, 8'h0F, 8'h00, 8'hFF, 3'b100, 3'b100);
      alu(ALU_OR, 8'h00, 8'h00, 8'h00, 8'hFF, 3'b100, 3'b100);
      alu(ALU_XOR, 8'hAA, 8'h55, 8'hFF, 8'hFF, 3'b000, 3'b100);
      alu(ALU_RRC, 8'h01, 8'h00, 8'h00, 8'h7F, 3'b001, 3'b001);
      alu(ALU_RLC, 8'h80, 8'h00, 8'h00, 8'hFE, 3'b001, 3'b001);
      $display("alu flags done");
   endtask

   task automatic t_ram();
      wr(OFS_RAM_SEL, 32'h0000_000C);
      wr(OFS_INDIRECT, 32'h0000_005A);
      wr(OFS_RAM_SEL, 32'h0000_008C);
      rd(OFS_INDIRECT);
      `CHK(rdata, 32'h0000_005A)
      rd(OFS_RAM_BASE + 8'h0C);
      `CHK(rdata, 32'h0000_005A)
      wr(OFS_RAM_SEL, 32'h0000_0020);
      wr(OFS_INDIRECT, 32'h0000_0011);
      wr(OFS_RAM_SEL, 32'h0000_0060);
      wr(OFS_INDIRECT, 32'h0000_0077);
      wr(OFS_RAM_SEL, 32'h0000_0020);
      rd(OFS_INDIRECT);
      `CHK(rdata, 32'h0000_0011)
      rd(OFS_RAM_BASE + 8'h3C);
      `CHK(rdata, 32'h0000_0077)
      $display("ram select done");
   endtask

   task automatic t_ports();
      for (int i = 0; i < 5; i++) begin
         rd(OFS_PORT5 + 8'(4 * i));
         `CHK(rdata[7:0], pins[8*i+:8])
         `CHK(serr, 1'b0)
         wr(OFS_PORT5 + 8'(4 * i), {24'h0, 8'(8'hA0 + i)});
         settle();
         `CHK(latch[8*i+:8], 8'(8'hA0 + i))
      end
      wr(OFS_CTRL_SPACE, 32'h0000_003C);
      rd(OFS_CTRL_SPACE);
      `CHK(rdata, 32'h0000_003C)
      rd(8'h40);
      `CHK(serr, 1'b1)
      `CHK(rdata, RDATA_ZERO)
      apb(32'h0000_0104, 1'b0, 32'h0000_0000);
      `CHK(serr, 1'b1)
      $display("ports done");
   endtask

   task automatic t_watchdog();
      wr(OFS_CORE_CTRL, 32'h0000_0004);
      rd(OFS_STATUS);
      `CHK(rdata[4:3], 2'b01)
      // power-down flag is one here, so a kept value is visible
      wr(OFS_TIMER, 32'h0000_0055);
      wr(OFS_CORE_CTRL, 32'h0000_0100);
      rd(OFS_STATUS);
      `CHK(rdata[4:3], 2'b01)
      rd(OFS_TIMER);
      `CHK(rdata, 32'h0000_0000)
      `CHK(fetch, RESET_VECTOR)
      wr(OFS_CORE_CTRL, 32'h0000_0002);
      rd(OFS_STATUS);
      `CHK(rdata[4:3], 2'b10)
      wr(OFS_CORE_CTRL, 32'h0000_0001);
      rd(OFS_STATUS);
      `CHK(rdata[4:3], 2'b11)
      wr(OFS_CORE_CTRL, 32'h0000_0004);
      wr(OFS_CORE_CTRL, 32'h0000_0008);
      rd(OFS_STATUS);
      `CHK(rdata[4:3], 2'b10)
      $display("watchdog flags done");
   endtask

   initial begin
      repeat (10) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      settle();
      t_reset();
      t_timer();
      t_page();
      t_alu();
      t_ram();
      t_ports();
      t_watchdog();
      close_out();
   end
endmodule
`default_nettype wire
